// [src/psm_defs.svh]
// Constants for the simple-mode macrocell block.
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_NCELL 8
`define PSM_NPT 8
`define PSM_NIN 20
`define PSM_NARR 40
`define PSM_CENTER_A 3
`define PSM_CENTER_B 4
`define PSM_ADDR_GLOBAL 12'h000
`define PSM_ADDR_CELL 12'h004
`define PSM_ADDR_PTSEL 12'h008
`define PSM_ADDR_STATUS 12'h00c
`define PSM_ADDR_OUT 12'h010
`define PSM_ADDR_PT0 12'h100
`define PSM_ADDR_PTEN0 12'h200
`define PSM_RESP_OKAY 2'b00
`define PSM_RESP_SLVERR 2'b10
`define PSM_TRECOV_NS 30
`define PSM_TRECOV_CYC ((`PSM_TRECOV_NS + 9) / 10)
`endif

// [src/psm_pkg.sv]
// Types for the simple-mode macrocell block.
package psm_pkg;
  typedef enum logic [1:0] {
    PSM_ACTIVE,
    PSM_DOWN,
    PSM_RECOVER
  } psm_pwr_type;
endpackage

// [src/psm_macrocell.sv]
// Simple-mode output macrocell array with power-down input and AXI4-Lite configuration port.
// Overview of operation
// - Cells are dedicated inputs or outputs driven whenever simple mode runs.
// - Each output sums up to eight product terms.
// - Polarity bit clear gives active-low output.
// - Simple mode needs mode bits 1,0; centres output.
// - Direction clear: output, with array feedback except for the centre cells.
// - Direction set: driver off, pin is input.
// - Centre cells never act as inputs.
// - Clock and enable pins are plain data inputs.
// - Power-down pin never feeds the array.
// - Outputs unguaranteed during standby recovery interval.
// - Power-down high holds standby; low resumes.
// - Inputs latched on standby entry.
`timescale 1ns/1ns
`include "psm_defs.svh"
module psm_macrocell (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Dedicated pins.
  input wire logic [11:0] data_pin,
  input wire logic clk_pin,
  input wire logic oe_pin,
  input wire logic powerdown_pin,
  // Macrocell pins.
  input wire logic [7:0] cell_pin_in,
  output logic [7:0] cell_pin_out,
  output logic [7:0] cell_pin_oe,
  // Status.
  output logic simple_mode,
  output logic outputs_valid,
  // AXI4-Lite write address.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import psm_pkg::*;

  // Register map seen from the configuration port.
  // The global word at offset zero holds the two mode bits; it stays writable at all times.
  // The cell word holds the polarity byte in its low lane and the direction byte in the next lane.
  // A polarity bit set gives an active-high output; a direction bit set makes the cell an input.
  // The term-select word returns the upper eight literals of term 2 (the third term of cell 0) and is otherwise reserved.
  // The status word reports outputs valid, standby, the power-down pin and simple mode, low bit last.
  // The output word mirrors the output enables above the output values.
  // Each term word loads one AND mask; the upper eight literals repeat the low data byte.
  // Each enable word holds one bit per term of one cell; a cleared bit drops the term from the sum.
  // Cell, term and enable words refuse writes while simple mode runs and the array is awake.

  // Architecture bits: bit 0 and bit 1 of the global register are the two mode bits.
  logic global_mode_bit_a;
  logic global_mode_bit_b;
  logic [7:0] polarity;
  logic [7:0] cell_direction_bit;

  // Product-term AND masks, eight per cell, and their enables.
  logic [`PSM_NARR-1:0] pt_and [0:`PSM_NCELL*`PSM_NPT-1];
  logic [7:0] pt_en [0:`PSM_NCELL-1];

  // Power-down state and recovery count.
  psm_pwr_type pwr_state;
  psm_pwr_type next_pwr_state;
  logic [3:0] recov_cnt;

  // Input latches for standby.
  logic [11:0] lat_data;
  logic lat_clk;
  logic lat_oe;
  logic [7:0] lat_cell;

  // Feedback of each cell into the array.
  logic [7:0] fb;

  // Bus channel state.
  // A beat taken on one channel is held here until its partner arrives.
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Simple mode is the one pairing of the mode bits that this block implements.
  // Any other pairing leaves every driver off, so no cell drives its pin; output cells still feed back their value.
  wire is_simple = global_mode_bit_a & ~global_mode_bit_b;
  wire standby = (pwr_state == PSM_DOWN);

  // Input buffers are transparent while active and hold their value in standby.
  // The latches copy every pin but the power-down pin while the block is awake, one edge behind the pin.
  // On entering standby the copy taken at the last awake edge is what the array sees.
  // Driving a pin in standby has no effect until the block wakes again.
  wire [11:0] in_data = standby ? lat_data : data_pin;
  wire in_clk = standby ? lat_clk : clk_pin;
  wire in_oe = standby ? lat_oe : oe_pin;
  wire [7:0] in_cell = standby ? lat_cell : cell_pin_in;

  // Array inputs: twelve data pins, clock and enable pins as data, six cell feeds; powerdown_pin is absent.
  // Inputs 0 to 11 are the data pins, 12 the clock pin and 13 the enable pin, both plain data here.
  // Inputs 14 to 19 are the feedbacks of cells 0, 1, 2, 5, 6 and 7 in that order.
  // The two centre cells have no feedback path, so they take no array input.
  // The power-down pin has no place in this list and cannot reach any term.
  wire [19:0] arr_in = {fb[7:5], fb[2:0], in_oe, in_clk, in_data};
  wire [`PSM_NARR-1:0] arr_lit;
  wire [7:0] cell_sum;
  wire [7:0] cell_val;
  wire [7:0] next_oe;

  // One literal pair per array input, then one sum per cell.
  genvar gi;
  generate
    for (gi = 0; gi < `PSM_NIN; gi = gi + 1) begin : g_lit
      assign arr_lit[2*gi] = arr_in[gi];
      assign arr_lit[2*gi+1] = ~arr_in[gi];
    end
    for (gi = 0; gi < `PSM_NCELL; gi = gi + 1) begin : g_cell
      wire [7:0] term;
      wire centre = (gi == `PSM_CENTER_A) || (gi == `PSM_CENTER_B);
      // The centre cells ignore their direction bit and drive whenever simple mode runs.
      wire as_input = cell_direction_bit[gi] & ~centre;
      for (genvar t = 0; t < `PSM_NPT; t = t + 1) begin : g_pt
        // An erased term with no literals selected reads true; the enable drops it from the sum.
        assign term[t] = pt_en[gi][t] & (&(~pt_and[gi*`PSM_NPT+t] | arr_lit));
      end
      assign cell_sum[gi] = |term;
      assign cell_val[gi] = cell_sum[gi] ^ ~polarity[gi];
      assign next_oe[gi] = is_simple & ~as_input;
      // Centre cells feed nothing back; input cells feed their pin; output cells feed their value.
      assign fb[gi] = centre ? 1'b0 : (as_input ? in_cell[gi] : cell_val[gi]);
    end
  endgenerate

  // Power-down state machine.
  // A high power-down pin moves the block into standby at the next edge.
  // In standby the input buffers hold their last values and the output values stay frozen; the enables still follow the configuration.
  // A low pin starts the recovery count; a new high pin during recovery returns to standby.
  // Outputs are marked invalid until the count has run its full length.
  // The clock keeps running in every state; edges during recovery update the output pins while the valid flag stays low.
  // The power-down pin feeds only this state machine and the status word.
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PSM_ACTIVE: if (powerdown_pin) next_pwr_state = PSM_DOWN;
      PSM_DOWN: if (!powerdown_pin) next_pwr_state = PSM_RECOVER;
      PSM_RECOVER: begin
        if (powerdown_pin) next_pwr_state = PSM_DOWN;
        else if (recov_cnt == 4'(`PSM_TRECOV_CYC - 1)) next_pwr_state = PSM_ACTIVE;
      end
      default: next_pwr_state = PSM_ACTIVE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_state <= PSM_ACTIVE;
      recov_cnt <= 4'h0;
      lat_data <= 12'h000;
      lat_clk <= 1'b0;
      lat_oe <= 1'b0;
      lat_cell <= 8'h00;
    end else begin
      pwr_state <= next_pwr_state;
      // The recovery count runs only in the recovery state and restarts from zero on each entry.
      recov_cnt <= (pwr_state == PSM_RECOVER) ? recov_cnt + 4'h1 : 4'h0;
      if (!standby) begin
        lat_data <= data_pin;
        lat_clk <= clk_pin;
        lat_oe <= oe_pin;
        lat_cell <= cell_pin_in;
      end
    end
  end

  // Output pins, registered; cell_pin_out is held in standby, cell_pin_oe is not.
  // Outside standby, a cell that does not drive its pin shows zero on its output register.
  // The enables follow the mode at once, so leaving simple mode releases every pin.
  // The valid flag looks one state ahead, so it drops on the edge that enters standby.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_pin_out <= 8'h00;
      cell_pin_oe <= 8'h00;
      simple_mode <= 1'b0;
      outputs_valid <= 1'b0;
    end else begin
      if (!standby) cell_pin_out <= cell_val & next_oe;
      cell_pin_oe <= next_oe;
      simple_mode <= is_simple;
      outputs_valid <= (next_pwr_state == PSM_ACTIVE);
    end
  end

  // Write path: address and data are taken in either order.
  // Each channel drops its ready for the cycle after a beat is taken and while the beat is held.
  // Once both beats are held, the response rises on the next edge and the beat is applied there.
  // A held pair waits while an earlier response is still unread.
  // Refused writes still answer, with a slave error, and change nothing.
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire [11:0] wa = aw_addr;
  wire wa_global = (wa == `PSM_ADDR_GLOBAL);
  wire wa_cell = (wa == `PSM_ADDR_CELL);
  wire wa_pt = (wa[11:8] == 4'h1) && (wa[1:0] == 2'b00);
  wire wa_pten = (wa[11:5] == 7'h10) && (wa[1:0] == 2'b00);
  wire wa_ok = wa_global | wa_cell | wa_pt | wa_pten;
  wire [5:0] wa_pt_idx = wa[7:2];
  wire [2:0] wa_pten_idx = wa[4:2];
  // Polarity, direction, term and enable bits may only change while the array is idle in standby or outside simple mode.
  wire cfg_open = standby | ~is_simple;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSM_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_fire;
      s_axi_wready <= ~w_held & ~w_fire;
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // The response code reflects the address and cfg_open checks that gate the register writes, but not the byte strobes.
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa_ok && (cfg_open || wa_global)) ? `PSM_RESP_OKAY : `PSM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; byte lane 0 carries the mode bits and polarity, lane 1 the directions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_mode_bit_a <= 1'b0;
      global_mode_bit_b <= 1'b0;
      polarity <= 8'h00;
      cell_direction_bit <= 8'h00;
    end else if (wr_go) begin
      if (wa_global && w_strb[0]) begin
        global_mode_bit_a <= w_data[0];
        global_mode_bit_b <= w_data[1];
      end
      if (wa_cell && cfg_open && w_strb[0]) polarity <= w_data[7:0];
      if (wa_cell && cfg_open && w_strb[1]) cell_direction_bit <= w_data[15:8];
    end
  end

  // Product-term store; no reset, as it is configuration memory loaded by software.
  // A term left unwritten holds unknown literals, so software must write it before enabling it.
  always_ff @(posedge aclk) begin
    if (wr_go && wa_pt && cfg_open) pt_and[wa_pt_idx] <= {w_data[7:0], w_data[31:0]};
  end

  // Term enables, one byte per cell.
  always_ff @(posedge aclk) begin
    if (wr_go && wa_pten && cfg_open) pt_en[wa_pten_idx] <= w_data[7:0];
  end

  // Read path.
  // The address is decoded while it is offered and the word is captured as it is taken.
  // Ready stays low while an answer is unread, so one read at most is under way.
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire [11:0] ra = s_axi_araddr;
  wire ra_pt = (ra[11:8] == 4'h1) && (ra[1:0] == 2'b00);
  wire ra_pten = (ra[11:5] == 7'h10) && (ra[1:0] == 2'b00);
  wire [`PSM_NARR-1:0] rd_pt = pt_and[ra[7:2]];
  // Status reports the internal standby state beside the raw pin itself.
  wire [31:0] rd_status = {28'h0, outputs_valid, standby, powerdown_pin, is_simple};
  wire ra_ok = (ra == `PSM_ADDR_GLOBAL) | (ra == `PSM_ADDR_CELL) | (ra == `PSM_ADDR_PTSEL) |
               (ra == `PSM_ADDR_STATUS) | (ra == `PSM_ADDR_OUT) | ra_pt | ra_pten;
  wire [31:0] rd_global = {30'h0, global_mode_bit_b, global_mode_bit_a};
  wire [31:0] rd_cell = {16'h0, cell_direction_bit, polarity};
  wire [31:0] rd_ptsel = {24'h0, rd_pt[39:32]};
  wire [31:0] rd_out = {16'h0, cell_pin_oe, cell_pin_out};
  wire [31:0] rd_pten = {24'h0, pt_en[ra[4:2]]};
  wire [31:0] rd_val =
    (ra == `PSM_ADDR_GLOBAL) ? rd_global :
    (ra == `PSM_ADDR_CELL) ? rd_cell :
    (ra == `PSM_ADDR_PTSEL) ? rd_ptsel :
    (ra == `PSM_ADDR_STATUS) ? rd_status :
    (ra == `PSM_ADDR_OUT) ? rd_out :
    ra_pt ? rd_pt[31:0] :
    ra_pten ? rd_pten : 32'h0;

  // Read answer register; the word stays put until it is taken.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PSM_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire & ~s_axi_arready;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= ra_ok ? `PSM_RESP_OKAY : `PSM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // psm_macrocell

// [tb/psm_macrocell_checker.sv]
// Concurrent checks on the ports of the simple-mode macrocell block.
`timescale 1ns/1ns
module psm_macrocell_checker (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and status.
  input wire logic powerdown_pin,
  input wire logic [7:0] cell_pin_out,
  input wire logic [7:0] cell_pin_oe,
  input wire logic simple_mode,
  input wire logic outputs_valid,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mode_drive_a: assert property (!simple_mode[*2] |-> cell_pin_oe == 8'h00)
    else $error("driver on outside simple mode");
  centre_drive_a: assert property ((simple_mode && outputs_valid)[*2] |-> cell_pin_oe[4:3] == 2'b11)
    else $error("centre cell not driving");
  off_drive_a: assert property ($stable(cell_pin_oe) |-> (cell_pin_out & ~cell_pin_oe) == 8'h00)
    else $error("value on an undriven cell");
  standby_enter_a: assert property (powerdown_pin |=> !outputs_valid)
    else $error("outputs valid in standby");
  wake_delay_a: assert property ($fell(powerdown_pin) |-> !outputs_valid[*3] ##[1:2] outputs_valid)
    else $error("wrong recovery length");
  output_hold_a: assert property (powerdown_pin[*2] |=> $stable(cell_pin_out))
    else $error("outputs moved in standby");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("no write answer");
  cover property ($rose(simple_mode));
  cover property ($fell(powerdown_pin));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // psm_macrocell_checker
bind psm_macrocell psm_macrocell_checker chk (.*);

// [tb/test_psm_macrocell.sv]
// Self-checking bench for the simple-mode macrocell block.
`timescale 1ns/1ns
module test_psm_macrocell;
  localparam logic [63:0] pten = 64'h00ff000101010101;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] data_pin = 12'h000;
  logic clk_pin = 1'b0, oe_pin = 1'b0, powerdown_pin = 1'b0;
  logic [7:0] pin_drv = 8'h00;
  logic [7:0] cell_pin_out, cell_pin_oe;
  // A cell pin shows the cell's own value while it drives, else the outside level.
  wire [7:0] cell_pin_in = (cell_pin_oe & cell_pin_out) | (~cell_pin_oe & pin_drv);
  logic simple_mode, outputs_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q [$];
  int n_fail = 0;
  int samples_checked = 0;

  psm_macrocell uut (.*);

  always #5 aclk = ~aclk;

  task automatic conclude();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g);
    logic [33:0] e;
    e = exp_q.pop_front();
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata});
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        @(posedge aclk iff s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({2'b00, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic stir();
    data_pin <= 12'($urandom);
    clk_pin <= 1'($urandom);
    oe_pin <= 1'($urandom);
    pin_drv <= 8'($urandom);
    repeat (4) @(posedge aclk);
  endtask

  function automatic logic [31:0] out_exp();
    return {16'h0, 8'hdf, 1'b1, |data_pin[11:4], 1'b0, data_pin[3] & data_pin[1] & pin_drv[5],
      data_pin[4], oe_pin, ~clk_pin, data_pin[4]};
  endfunction

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  initial begin
    void'($urandom(32'hab30));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 32'h0);
    rd(12'h00c, 32'h8);
    wr(12'h800, 32'h1, 2'b10);
    wr(12'h000, 32'h3, 2'b00);
    rd(12'h00c, 32'h8);
    $display("reset and map test done");
    wr(12'h004, 32'h285d, 2'b00);
    for (int c = 0; c < 8; c++) wr(12'h200 + 12'(4 * c), {24'h0, pten[8 * c +: 8]}, 2'b00);
    for (int k = 0; k < 8; k++) wr(12'h1c0 + 12'(4 * k), 32'h100 << (2 * k), 2'b00);
    wr(12'h100, 32'h100, 2'b00);
    wr(12'h120, 32'h0100_0000, 2'b00);
    wr(12'h140, 32'h0400_0000, 2'b00);
    wr(12'h160, 32'h1000_0000, 2'b00);
    wr(12'h180, 32'h44, 2'b00);
    wr(12'h000, 32'h1, 2'b00);
    rd(12'h00c, 32'h9);
    for (int i = 0; i < 8; i++) begin
      stir();
      rd(12'h010, out_exp());
      exp_q.push_back({2'b00, out_exp()});
      chk({2'b00, 16'h0, cell_pin_oe, cell_pin_out});
    end
    $display("logic test done");
    wr(12'h004, 32'h0, 2'b10);
    rd(12'h010, out_exp());
    $display("lock test done");
    powerdown_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(12'h00c, 32'h7);
    exp_q.push_back(34'h2);
    chk({32'h0, simple_mode, outputs_valid});
    data_pin <= ~data_pin;
    @(posedge aclk);
    powerdown_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(12'h010, out_exp());
    rd(12'h00c, 32'h9);
    exp_q.push_back(34'h3);
    chk({32'h0, simple_mode, outputs_valid});
    $display("standby test done");
    wr(12'h000, 32'h0, 2'b00);
    repeat (3) @(posedge aclk);
    rd(12'h010, 32'h0);
    $display("mode exit test done");
    conclude();
  end
endmodule // test_psm_macrocell
